// ---- include/ppf_pkg.sv ----
// Purpose: constants shared by the position feedback logic
// Assumes: 25 MHz system clock
// Notes:   select codes are one per decoded output line

package ppf_pkg;

  // system clock rate and settling time
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned SETTLE_MS       = 100;
  localparam int unsigned SETTLE_CYCLES   = (CLK_HZ / 1000) * SETTLE_MS;

  // select line decode (4-bit binary code on select lines)
  localparam logic [3:0] SEL_HIGH_NIBBLE  = 4'h0;
  localparam logic [3:0] SEL_LOW_BYTE     = 4'h1;
  localparam logic [3:0] SEL_GATE_CMD     = 4'h2;
  localparam logic [3:0] SEL_GATE_STATUS  = 4'h3;
  localparam logic [3:0] SEL_GATE_JUMPER  = 4'h4;
  localparam logic [3:0] SEL_CLR_RIBBON   = 4'h5;
  localparam logic [3:0] SEL_CLR_RESTORE  = 4'h6;
  localparam logic [3:0] SEL_CLR_CARRIAGE = 4'h7;
  localparam logic [3:0] SEL_SET_WHEEL    = 4'h8;
  localparam int unsigned SEL_COUNT       = 10;

  // status byte field positions
  localparam int unsigned ST_CARRIAGE_EVEN_PHASE     = 0;
  localparam int unsigned ST_WHEEL_EVEN   = 1;
  localparam int unsigned ST_CARRIAGE_HOME_FLAG     = 2;
  localparam int unsigned ST_WHEEL_HOME   = 3;

  // command byte field positions
  localparam int unsigned CMD_RIB_RAISE   = 0;
  localparam int unsigned CMD_RIB_LOWER   = 1;
  localparam int unsigned CMD_RIB_REQ     = 2;
  localparam int unsigned CMD_RESTORE     = 3;

  // apb register map (byte addresses)
  localparam logic [7:0] REG_CONTROL      = 8'h00;
  localparam logic [7:0] REG_STATUS       = 8'h04;
  localparam logic [7:0] REG_COMMAND      = 8'h08;
  localparam logic [7:0] REG_JUMPER       = 8'h0c;

  // control register fields
  localparam int unsigned CTL_RESTORE     = 0;
  localparam int unsigned CTL_READY_BUSY  = 1;

  // control register reset value
  localparam logic [1:0] CTL_RESET        = 2'h1;

endpackage

// ---- hw/ppf_core.sv ----
// Purpose: ribbon latch, status synchronizers, carriage and wheel count
//          generators, select decoder and byte read-out
// Assumes: single system clock; all servo inputs asynchronous to it
// Notes:   count pulses are sticky flags cleared by the acknowledge inputs
//
// Function
// - ribbon raise and lower each set a flop
// - ribbon command holds wheel ready busy 100ms
// - latched ribbon command forwarded as request
// - resync even and home inputs to clock
// - four synced status bits gated to bus
// - one carriage pulse per 1/120 inch
// - even sampled alternately on phase xor
// - sample after even change sets carriage flag
// - carriage flag held until ack clear
// - wheel gives separate increment and decrement pulses
// - wheel outputs clocked by inverted phase xor
// - staging compared with even, gated, spurious rejected
// - two active-low wheel pulses per petal
// - wheel outputs preset by wheel acknowledge
// - decode select lines to one active-low output
// - decoder clears flops or addresses drivers
// - twelve-bit word read as nibble then byte
// - command, status and jumper gate selects
// - restore blocks strobes, forces all ready busy

`timescale 1ns/1ps

module ppf_core #(
  parameter int unsigned SETTLE_CYCLES = ppf_pkg::SETTLE_CYCLES,
  parameter int unsigned JUMPER_W      = 8
) (
  input  wire logic                 sys_clk_in,
  input  wire logic                 nrst_in,
  // apb slave
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [7:0]           paddr_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  // ribbon commands from the line receiver
  input  wire logic                 ribbon_raise_in,
  input  wire logic                 ribbon_lower_in,
  input  wire logic                 strobe_in,
  // servo feedback
  input  wire logic                 carriage_even_phase_in,
  input  wire logic                 carriage_phase_a_in,
  input  wire logic                 carriage_phase_b_in,
  input  wire logic                 carriage_home_flag_in,
  input  wire logic                 wheel_even_phase_in,
  input  wire logic                 wheel_phase_a_in,
  input  wire logic                 wheel_phase_b_in,
  input  wire logic                 wheel_home_flag_in,
  // microprocessor side
  input  wire logic                 carriage_count_ack_n_in,
  input  wire logic                 wheel_count_ack_n_in,
  input  wire logic [3:0]           select_code_in,
  input  wire logic                 input_enable_n_in,
  input  wire logic                 select_reset_n_in,
  input  wire logic [11:0]          command_word_in,
  input  wire logic [JUMPER_W-1:0]  jumper_in,
  output logic      [7:0]           mpu_bus_out,
  output logic      [ppf_pkg::SEL_COUNT-1:0] select_n_out,
  output logic                      low_byte_select_n_out,
  output logic                      high_nibble_select_n_out,
  output logic                      ribbon_request_out,
  output logic                      carriage_count_out,
  output logic                      wheel_inc_n_out,
  output logic                      wheel_dec_n_out,
  output logic                      wheel_ready_n_out,
  output logic                      ready_n_out,
  output logic                      strobe_accept_out
);

  localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 1);

  // one-hot active-low decode of a select code
  function automatic logic [ppf_pkg::SEL_COUNT-1:0] decode_sel(input logic [3:0] code,
                                                               input logic       en);
    logic [ppf_pkg::SEL_COUNT-1:0] v;
    v = '1;
    if (en && (32'(code) < ppf_pkg::SEL_COUNT))
    begin
      v[code] = 1'b0;
    end
    return v;
  endfunction

  // direction of a phase step: true when a lags b, as on a forward move
  function automatic logic phase_fwd(input logic b,
                                     input logic pa);
    return b ^ pa;
  endfunction

  // synchroniser stages and internal signals
  logic [3:0] st_meta;
  logic [3:0] st_sync;
  logic [5:0] ph_meta;
  logic [5:0] ph_sync;
  logic [5:0] ph_last;
  logic       restore;
  logic       ready_force;
  logic       rib_raise;
  logic       rib_lower;
  logic [CNT_W-1:0] settle_cnt;
  logic       car_stage0;
  logic       car_stage1;
  logic       car_sel;
  logic       whl_stage0;
  logic       whl_stage1;
  logic       rib_take;
  logic       dec_en;
  logic [ppf_pkg::SEL_COUNT-1:0] next_sel_n;
  logic       apb_write;
  logic       apb_read;
  logic       car_step;
  logic       whl_step;
  logic       whl_fwd;
  logic       clr_ribbon;
  logic       clr_restore;
  logic       clr_carriage;
  logic       set_wheel;

  // system-clock synchronisers; first stage is read only by the second
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      st_meta <= 4'h0;
      st_sync <= 4'h0;
      ph_meta <= 6'h00;
      ph_sync <= 6'h00;
      ph_last <= 6'h00;
    end
    else
    begin
      st_meta <= {wheel_home_flag_in, carriage_home_flag_in,
                  wheel_even_phase_in, carriage_even_phase_in};
      st_sync <= st_meta;
      ph_meta <= {wheel_even_phase_in, wheel_phase_b_in, wheel_phase_a_in,
                  carriage_even_phase_in, carriage_phase_b_in, carriage_phase_a_in};
      ph_sync <= ph_meta;
      ph_last <= ph_sync;
    end
  end

  // select decode, gated by input enable and the reset strobe
  assign dec_en       = !input_enable_n_in || !select_reset_n_in;
  assign next_sel_n   = decode_sel(select_code_in, dec_en);
  assign clr_ribbon   = !next_sel_n[ppf_pkg::SEL_CLR_RIBBON];
  assign clr_restore  = !next_sel_n[ppf_pkg::SEL_CLR_RESTORE];
  assign clr_carriage = !next_sel_n[ppf_pkg::SEL_CLR_CARRIAGE];
  assign set_wheel    = !next_sel_n[ppf_pkg::SEL_SET_WHEEL];

  // apb and ribbon strobes; slave answers with no wait states
  assign apb_write = psel_in && penable_in && pwrite_in;
  assign apb_read  = psel_in && !pwrite_in;
  assign rib_take  = strobe_in && !restore;

  // phase edges: xor of a and b changes once per quarter cycle
  assign car_step = (ph_sync[0] ^ ph_sync[1]) != (ph_last[0] ^ ph_last[1]);
  assign whl_step = (!ph_sync[3] ^ !ph_sync[4]) != (!ph_last[3] ^ !ph_last[4]);
  assign whl_fwd  = phase_fwd(ph_sync[4], ph_last[3]);

  // control register: restore flop and forced-busy bit
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      restore     <= ppf_pkg::CTL_RESET[ppf_pkg::CTL_RESTORE];
      ready_force <= ppf_pkg::CTL_RESET[ppf_pkg::CTL_READY_BUSY];
    end
    else if (apb_write && paddr_in == ppf_pkg::REG_CONTROL)
    begin
      restore     <= pwdata_in[ppf_pkg::CTL_RESTORE];
      ready_force <= pwdata_in[ppf_pkg::CTL_READY_BUSY];
    end
    else if (clr_restore)
    begin
      restore <= 1'b0;
    end
  end

  // ribbon flops; restore blocks strobe acceptance, a set wins over a clear
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rib_raise <= 1'b0;
      rib_lower <= 1'b0;
    end
    else
    begin
      rib_raise <= (rib_take && ribbon_raise_in) || (rib_raise && !clr_ribbon);
      rib_lower <= (rib_take && ribbon_lower_in) || (rib_lower && !clr_ribbon);
    end
  end

  // settling counter reloads on every accepted ribbon command
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      settle_cnt <= '0;
    end
    else if (rib_take && (ribbon_raise_in || ribbon_lower_in))
    begin
      settle_cnt <= CNT_W'(SETTLE_CYCLES);
    end
    else if (settle_cnt != '0)
    begin
      settle_cnt <= settle_cnt - CNT_W'(1);
    end
  end

  // carriage: even level staged alternately on each xor step
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      car_stage0    <= 1'b0;
      car_stage1    <= 1'b0;
      car_sel       <= 1'b0;
    end
    else if (car_step)
    begin
      car_sel <= !car_sel;
      if (car_sel)
      begin
        car_stage1 <= ph_sync[2];
      end
      else
      begin
        car_stage0 <= ph_sync[2];
      end
    end
  end

  // carriage flag: set after an even change, set wins over clear
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      carriage_count_out <= 1'b0;
    end
    else if (car_step && ph_sync[2] != (car_sel ? car_stage0 : car_stage1))
    begin
      carriage_count_out <= 1'b1;
    end
    else if (!carriage_count_ack_n_in || clr_carriage)
    begin
      carriage_count_out <= 1'b0;
    end
  end

  // wheel staging flops shift in the even level on each inverted xor step
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      whl_stage0    <= 1'b0;
      whl_stage1    <= 1'b0;
    end
    else if (whl_step)
    begin
      whl_stage1    <= whl_stage0;
      whl_stage0    <= ph_sync[5];
    end
  end

  // wheel outputs: only an even change with matching staging counts,
  // and only while no count is pending, so noise cannot double-count
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wheel_inc_n_out <= 1'b1;
      wheel_dec_n_out <= 1'b1;
    end
    else if (whl_step && ph_sync[5] != whl_stage0 && whl_stage0 == whl_stage1
             && wheel_inc_n_out && wheel_dec_n_out)
    begin
      wheel_inc_n_out <= !whl_fwd;
      wheel_dec_n_out <= whl_fwd;
    end
    else if (!wheel_count_ack_n_in || set_wheel)
    begin
      wheel_inc_n_out <= 1'b1;
      wheel_dec_n_out <= 1'b1;
    end
  end

  // ready lines and registered status outputs
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wheel_ready_n_out  <= 1'b1;
      ready_n_out        <= 1'b1;
      ribbon_request_out <= 1'b0;
      strobe_accept_out  <= 1'b0;
    end
    else
    begin
      wheel_ready_n_out  <= restore || ready_force || settle_cnt != '0;
      ready_n_out        <= restore || ready_force;
      ribbon_request_out <= rib_raise || rib_lower;
      strobe_accept_out  <= !restore;
    end
  end

  // decoder outputs registered for glitch-free selects
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      select_n_out             <= '1;
      low_byte_select_n_out    <= 1'b1;
      high_nibble_select_n_out <= 1'b1;
    end
    else
    begin
      select_n_out             <= next_sel_n;
      low_byte_select_n_out    <= next_sel_n[ppf_pkg::SEL_LOW_BYTE];
      high_nibble_select_n_out <= next_sel_n[ppf_pkg::SEL_HIGH_NIBBLE];
    end
  end

  // input bus mux: one source per gate select, idle reads zero
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mpu_bus_out <= 8'h00;
    end
    else
    begin
      mpu_bus_out <= 8'h00;
      if (!next_sel_n[ppf_pkg::SEL_HIGH_NIBBLE])
      begin
        mpu_bus_out <= {4'h0, command_word_in[11:8]};
      end
      if (!next_sel_n[ppf_pkg::SEL_LOW_BYTE])
      begin
        mpu_bus_out <= command_word_in[7:0];
      end
      if (!next_sel_n[ppf_pkg::SEL_GATE_STATUS])
      begin
        mpu_bus_out <= {4'h0, st_sync};
      end
      if (!next_sel_n[ppf_pkg::SEL_GATE_CMD])
      begin
        mpu_bus_out <= {4'h0, restore, rib_raise || rib_lower, rib_lower, rib_raise};
      end
      if (!next_sel_n[ppf_pkg::SEL_GATE_JUMPER])
      begin
        mpu_bus_out <= 8'(jumper_in);
      end
    end
  end

  // apb read data and answer; addresses above the jumper register error
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && paddr_in > ppf_pkg::REG_JUMPER;
      prdata_out  <= 32'h0000_0000;
      if (apb_read && !penable_in)
      begin
        unique case (paddr_in)
          ppf_pkg::REG_CONTROL: prdata_out <= {30'h0, ready_force, restore};
          ppf_pkg::REG_STATUS:  prdata_out <= {28'h0, st_sync};
          ppf_pkg::REG_COMMAND: prdata_out <= {27'h0, carriage_count_out,
                                               restore, rib_raise || rib_lower,
                                               rib_lower, rib_raise};
          ppf_pkg::REG_JUMPER:  prdata_out <= 32'(jumper_in);
          default:              prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ---- verif/ppf_servo_model.sv ----
// Purpose: servo side model driving quadrature and even-phase feedback
// Assumes: one quadrature step per call, spaced well apart
// Notes:   phases hold still between steps, as a halted motor does
`timescale 1ns/1ps

module ppf_servo_model (
  input  wire logic clk_in,
  output logic      phase_a_out,
  output logic      phase_b_out,
  output logic      even_out
);
  logic [1:0] pos;

  // idle at position zero
  initial
  begin
    pos = 2'h0;
    {phase_a_out, phase_b_out, even_out} = 3'h0;
  end

  // gray step; even flips on odd positions, so two flips per full cycle
  task automatic step(input logic fwd);
    @(posedge clk_in);
    pos = fwd ? pos + 2'h1 : pos - 2'h1;
    phase_a_out <= pos[1];
    phase_b_out <= pos[1] ^ pos[0];
    repeat (6) @(posedge clk_in);
    if (pos[0]) even_out <= ~even_out;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

// ---- verif/ppf_core_sva.sv ----
// Purpose: port-level checks of the position feedback core
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   ack checks need still phases so that a same-cycle set cannot win
`timescale 1ns/1ps

module ppf_core_sva #(
  parameter int unsigned SETTLE_CYCLES = ppf_pkg::SETTLE_CYCLES
) (
  input wire logic        sys_clk_in,
  input wire logic        nrst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic [7:0]  paddr_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        strobe_in,
  input wire logic        ribbon_raise_in,
  input wire logic        ribbon_lower_in,
  input wire logic        input_enable_n_in,
  input wire logic        select_reset_n_in,
  input wire logic [3:0]  select_code_in,
  input wire logic [11:0] command_word_in,
  input wire logic [7:0]  mpu_bus_out,
  input wire logic        ribbon_request_out,
  input wire logic        wheel_ready_n_out,
  input wire logic        ready_n_out,
  input wire logic        strobe_accept_out,
  input wire logic        carriage_count_ack_n_in,
  input wire logic        carriage_phase_a_in,
  input wire logic        carriage_phase_b_in,
  input wire logic        carriage_count_out,
  input wire logic        wheel_count_ack_n_in,
  input wire logic        wheel_phase_a_in,
  input wire logic        wheel_phase_b_in,
  input wire logic        wheel_inc_n_out,
  input wire logic        wheel_dec_n_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  // building blocks of the multi-step behaviours
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_cmd;
    strobe_in && (ribbon_raise_in || ribbon_lower_in) && strobe_accept_out
      && input_enable_n_in && select_reset_n_in;
  endsequence
  sequence s_car_ack;
    (!carriage_count_ack_n_in && $stable(carriage_phase_a_in)
      && $stable(carriage_phase_b_in)) [*6];
  endsequence
  sequence s_wh_ack;
    (!wheel_count_ack_n_in && $stable(wheel_phase_a_in)
      && $stable(wheel_phase_b_in)) [*6];
  endsequence

  a_apb_answer: assert property (s_setup |=> pready_out ##1 !pready_out)
    else $error("apb answer not a single cycle after setup");
  a_apb_badaddr: assert property (s_setup and paddr_in > 8'h0c |=> pslverr_out)
    else $error("unmapped address not flagged");
  a_ribbon_req: assert property (s_cmd |-> ##2 ribbon_request_out)
    else $error("ribbon command not forwarded");
  a_ribbon_busy: assert property (s_cmd |-> ##2 wheel_ready_n_out [*8])
    else $error("wheel ready not held busy after ribbon command");
  a_restore_busy: assert property (!strobe_accept_out
    |-> ready_n_out && wheel_ready_n_out)
    else $error("ready low while in restore");
  a_car_ack_clear: assert property (s_car_ack |=> !carriage_count_out)
    else $error("carriage flag survives acknowledge");
  a_wheel_preset: assert property (s_wh_ack |=> wheel_inc_n_out && wheel_dec_n_out)
    else $error("wheel outputs not preset by acknowledge");
  a_wheel_one_dir: assert property (wheel_inc_n_out || wheel_dec_n_out)
    else $error("both wheel count outputs active");
  a_nibble_read: assert property (!input_enable_n_in && select_code_in == 4'h0
    |=> mpu_bus_out == {4'h0, $past(command_word_in[11:8])})
    else $error("high nibble read wrong");
endmodule

bind ppf_core ppf_core_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_ppf_core_sva (
  .sys_clk_in, .nrst_in, .psel_in, .penable_in, .paddr_in, .pready_out, .pslverr_out,
  .strobe_in, .ribbon_raise_in, .ribbon_lower_in, .input_enable_n_in, .select_reset_n_in,
  .select_code_in, .command_word_in, .mpu_bus_out, .ribbon_request_out, .wheel_ready_n_out,
  .ready_n_out, .strobe_accept_out, .carriage_count_ack_n_in, .carriage_phase_a_in,
  .carriage_phase_b_in, .carriage_count_out, .wheel_count_ack_n_in, .wheel_phase_a_in,
  .wheel_phase_b_in, .wheel_inc_n_out, .wheel_dec_n_out);

// ---- verif/printer_position_feedback_logic_tb.sv ----
// Purpose: self-checking bench of the position feedback core
// Assumes: short settle count; servo models on both feedback paths
// Notes:   reads right after an edge see the settled pre-edge values
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module printer_position_feedback_logic_tb;
  localparam int unsigned ST = 20;
  logic        sys_clk_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic        ribbon_raise_in, ribbon_lower_in, strobe_in, carriage_home_flag_in;
  logic        wheel_home_flag_in, carriage_count_ack_n_in, wheel_count_ack_n_in;
  logic        input_enable_n_in, select_reset_n_in, low_byte_select_n_out;
  logic        high_nibble_select_n_out, ribbon_request_out, carriage_count_out;
  logic        wheel_inc_n_out, wheel_dec_n_out, wheel_ready_n_out, ready_n_out;
  logic        strobe_accept_out, carriage_even_phase_in, carriage_phase_a_in;
  logic        carriage_phase_b_in, wheel_even_phase_in, wheel_phase_a_in, wheel_phase_b_in;
  logic        er, fwd_line;
  logic [3:0]  select_code_in;
  logic [7:0]  paddr_in, mpu_bus_out, jumper_in;
  logic [11:0] command_word_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [ppf_pkg::SEL_COUNT-1:0] select_n_out;
  int          n_errors, comparisons, cycles;

  ppf_core #(.SETTLE_CYCLES(ST), .JUMPER_W(8)) i_ppf_core (
    .sys_clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .ribbon_raise_in, .ribbon_lower_in, .strobe_in,
    .carriage_even_phase_in, .carriage_phase_a_in, .carriage_phase_b_in,
    .carriage_home_flag_in, .wheel_even_phase_in, .wheel_phase_a_in, .wheel_phase_b_in,
    .wheel_home_flag_in, .carriage_count_ack_n_in, .wheel_count_ack_n_in, .select_code_in,
    .input_enable_n_in, .select_reset_n_in, .command_word_in, .jumper_in, .mpu_bus_out,
    .select_n_out, .low_byte_select_n_out, .high_nibble_select_n_out, .ribbon_request_out,
    .carriage_count_out, .wheel_inc_n_out, .wheel_dec_n_out, .wheel_ready_n_out,
    .ready_n_out, .strobe_accept_out);
  ppf_servo_model i_car (.clk_in(sys_clk_in), .phase_a_out(carriage_phase_a_in),
    .phase_b_out(carriage_phase_b_in), .even_out(carriage_even_phase_in));
  ppf_servo_model i_whl (.clk_in(sys_clk_in), .phase_a_out(wheel_phase_a_in),
    .phase_b_out(wheel_phase_b_in), .even_out(wheel_even_phase_in));

  // 25 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic test_done;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      test_done;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask

  // select code held for two edges through one of the two strobes
  task automatic sel(input logic [3:0] c, input logic r);
    @(posedge sys_clk_in);
    {select_code_in, input_enable_n_in, select_reset_n_in} <= {c, r, ~r};
    cyc(2);
  endtask
  task automatic rel;
    @(posedge sys_clk_in);
    {input_enable_n_in, select_reset_n_in} <= 2'b11;
  endtask

  task automatic t_restore;
    `CHK(strobe_accept_out, 1'b0)
    `CHK(ready_n_out, 1'b1)
    apb(1'b0, ppf_pkg::REG_CONTROL, 32'h0);
    `CHK(rd[1:0], ppf_pkg::CTL_RESET)
    @(posedge sys_clk_in);
    {ribbon_raise_in, strobe_in} <= 2'b11;
    @(posedge sys_clk_in);
    {ribbon_raise_in, strobe_in} <= 2'b00;
    cyc(4);
    `CHK(ribbon_request_out, 1'b0)
    apb(1'b1, ppf_pkg::REG_CONTROL, 32'h3);
    sel(ppf_pkg::SEL_CLR_RESTORE, 1'b1);
    rel;
    cyc(2);
    `CHK({strobe_accept_out, ready_n_out}, 2'b11)
    apb(1'b1, ppf_pkg::REG_CONTROL, 32'h0);
    cyc(2);
    `CHK(strobe_accept_out, 1'b1)
    `CHK(ready_n_out, 1'b0)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(er, 1'b1)
  endtask

  task automatic t_ribbon(input logic lw);
    `CHK(wheel_ready_n_out, 1'b0)
    @(posedge sys_clk_in);
    {ribbon_raise_in, ribbon_lower_in, strobe_in} <= {~lw, lw, 1'b1};
    @(posedge sys_clk_in);
    strobe_in <= 1'b0;
    cyc(3);
    `CHK(ribbon_request_out, 1'b1)
    `CHK(wheel_ready_n_out, 1'b1)
    apb(1'b0, ppf_pkg::REG_COMMAND, 32'h0);
    `CHK(rd[3:0], {2'b01, lw, ~lw})
    cyc(ST);
    `CHK(wheel_ready_n_out, 1'b0)
    sel(ppf_pkg::SEL_CLR_RIBBON, 1'b1);
    rel;
    cyc(2);
    `CHK(ribbon_request_out, 1'b0)
  endtask

  task automatic t_decode;
    command_word_in <= 12'habc;
    jumper_in <= 8'h5a;
    for (int c = 0; c < 11; c++)
    begin
      sel(4'(c == 10 ? 12 : c), 1'b0);
      `CHK(select_n_out, c == 10 ? 10'h3ff : ~(10'h1 << c))
      if (c == 0) `CHK({high_nibble_select_n_out, mpu_bus_out}, 9'h00a)
      if (c == 1) `CHK({low_byte_select_n_out, mpu_bus_out}, 9'h0bc)
      if (c == 4) `CHK(mpu_bus_out, 8'h5a)
      rel;
    end
  endtask

  task automatic t_status;
    for (int p = 1; p < 3; p++)
    begin
      {wheel_home_flag_in, carriage_home_flag_in} <= 2'(p);
      cyc(4);
      sel(ppf_pkg::SEL_GATE_STATUS, 1'b0);
      `CHK(mpu_bus_out[3:0], {2'(p), 2'b00})
      rel;
    end
  endtask

  // two carriage counts per full phase cycle, cleared by ack then by decoder
  task automatic t_carriage;
    for (int i = 0; i < 4; i++)
    begin
      i_car.step(1'b1);
      `CHK(carriage_count_out, 1'(i))
      if (i[0])
      begin
        cyc(10);
        `CHK(carriage_count_out, 1'b1)
        if (i == 1) carriage_count_ack_n_in <= 1'b0;
        else sel(ppf_pkg::SEL_CLR_CARRIAGE, 1'b1);
        cyc(10);
        carriage_count_ack_n_in <= 1'b1;
        rel;
        `CHK(carriage_count_out, 1'b0)
      end
    end
  endtask

  // one petal each way; the line used must follow the direction
  task automatic t_wheel(input logic d);
    for (int i = 0; i < 4; i++)
    begin
      i_whl.step(d);
      `CHK(wheel_inc_n_out ^ wheel_dec_n_out, 1'(i))
      if (i == 1 && d) fwd_line = wheel_inc_n_out;
      if (i[0]) `CHK(wheel_inc_n_out, d ? fwd_line : ~fwd_line)
      if (i < 3) wheel_count_ack_n_in <= 1'b0;
      else sel(ppf_pkg::SEL_SET_WHEEL, 1'b1);
      cyc(10);
      wheel_count_ack_n_in <= 1'b1;
      rel;
      `CHK({wheel_inc_n_out, wheel_dec_n_out}, 2'b11)
    end
  endtask

  // main sequence
  initial
  begin
    {nrst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {ribbon_raise_in, ribbon_lower_in, strobe_in, select_code_in} = '0;
    {carriage_home_flag_in, wheel_home_flag_in, command_word_in, jumper_in} = '0;
    {carriage_count_ack_n_in, wheel_count_ack_n_in} = 2'b11;
    {input_enable_n_in, select_reset_n_in} = 2'b11;
    {n_errors, comparisons, cycles, fwd_line} = '0;
    cyc(20);
    nrst_in <= 1'b1;
    t_restore;
    t_status;
    t_ribbon(1'b0);
    t_ribbon(1'b1);
    t_decode;
    t_carriage;
    t_wheel(1'b1);
    t_wheel(1'b0);
    test_done;
  end
endmodule
